// ==== rtl/usb_err_pkg.sv ====
// package: register map, field layout and timing for the usb error block
package usb_err_pkg;

    // ---------------------------------------------------------------
    // register byte offsets on the apb slave
    // ---------------------------------------------------------------
    localparam logic [7:0] error_flags_off   = 8'h00;
    localparam logic [7:0] error_enables_off = 8'h04;
    localparam logic [7:0] int_flags_off     = 8'h08;
    localparam logic [7:0] int_enables_off   = 8'h0c;
    localparam logic [7:0] control_off       = 8'h10;

    // ---------------------------------------------------------------
    // error register fields
    // ---------------------------------------------------------------
    localparam int packet_id_fail_bit    = 0;
    localparam int token_crc_fail_bit    = 1;
    localparam int data_crc_fail_bit     = 2;
    localparam int partial_byte_bit      = 3;
    localparam int turnaround_bit        = 4;
    localparam int bit_stuff_bit         = 7;
    localparam logic [7:0] error_impl_mask  = 8'h9f;
    localparam logic [7:0] error_flags_rst  = 8'h00;
    localparam logic [7:0] error_enable_rst = 8'h00;

    // ---------------------------------------------------------------
    // interrupt flag register fields
    // ---------------------------------------------------------------
    localparam int summary_bit  = 1;
    localparam int bus_idle_bit = 4;
    localparam logic [7:0] int_impl_mask   = 8'h12;
    localparam logic [7:0] int_enable_rst  = 8'h00;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int module_enable_bit = 0;
    localparam int pullup_enable_bit = 1;
    localparam int suspend_bit       = 2;
    localparam logic [2:0] control_rst = 3'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int clk_period_ns    = 10;
    localparam int idle_time_ms     = 3;
    localparam int idle_cycles      =
        idle_time_ms * 1000000 / clk_period_ns;
    localparam int idle_cnt_w       = 19;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic bit_stuff;
        logic turnaround;
        logic partial_byte;
        logic data_crc;
        logic token_crc;
        logic packet_id;
    } error_events_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage : usb_err_pkg

// ==== rtl/idle_timer.sv ====
// idle timer: counts quiet cycles and pulses once the limit is passed
`timescale 1ns/1ps
module idle_timer #(
    parameter int limit = usb_err_pkg::idle_cycles
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic activity,
    output logic      expired
);
    logic [usb_err_pkg::idle_cnt_w-1:0] count_q;
    logic                               fired_q;

    // fires once per quiet stretch; activity rearms it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_q <= '0;
            fired_q <= 1'b0;
        end else if (ce) begin
            if (activity) begin
                count_q <= '0;
                fired_q <= 1'b0;
            end else if (count_q > limit[usb_err_pkg::idle_cnt_w-1:0]) begin
                fired_q <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign expired = ce && !activity && !fired_q
                     && (count_q > limit[usb_err_pkg::idle_cnt_w-1:0]);

endmodule : idle_timer

// ==== rtl/usb_error_flag_aggregator.sv ====
// usb error flag capture, masking and summary, with idle and pull-up control
//
// Contract
// (RL1) summary flag is the OR of all error flags whose enables are set
// (RL2) each enable gates only its own flag toward the summary
// (RL3) flags are set by their events whatever the enables hold
// (RL4) a flag sets in the cycle its error is reported
// (RL5) a set flag stays set until software writes zero to it
// (RL6) bit 7 flags a bit stuffing violation
// (RL7) bit 4 flags turnaround time-out past 16 idle bit times after eop
// (RL8) bit 3 flags a data field that is not whole bytes
// (RL9) bit 2 flags a failed data crc16 check
// (RL10) bit 1 flags a token rejected on crc5 failure
// (RL11) bit 0 flags a failed packet identifier check
// (RL12) bits 6 and 5 of flag and enable registers read zero
// (RL13) one read/write enable per flag, same position, clear at reset
// (RL14) idle flag sets after more than 3 ms without bus traffic
// (RL15) pull-up stays enabled while suspended
// (RL16) firmware enables module and pull-up only once vbus is seen high
// (RL17) summary flag is read-only, following the enabled flags
// (RL18) summary sits at bit 1 of interrupt flags, gated by its enable
// (RL19) writing one keeps a flag; an event beats a clearing write
// (RL20) summary follows flags and enables combinationally
`timescale 1ns/1ps
module usb_error_flag_aggregator #(
    parameter int idle_limit = usb_err_pkg::idle_cycles
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          ce,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // from the serial interface engine, same clock
    input  wire usb_err_pkg::error_events_type error_events,
    input  wire logic                          bus_activity,
    // vbus sense pin, asynchronous
    input  wire logic                          vbus_sense,
    // outputs
    output logic                               usb_error_summary_flag,
    output logic                               usb_interrupt_request,
    output logic                               module_enable,
    output logic                               pullup_enable,
    output logic                               vbus_present
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] usb_error_flags_q;
    logic [7:0] usb_error_enables_q;
    logic [7:0] int_enables_q;
    logic       bus_idle_flag_q;
    logic [2:0] control_q;
    logic [2:0] vbus_sync_q;
    logic       vbus_present_q;
    logic [31:0] prdata_q;
    logic [7:0] usb_error_flags_d;
    logic [7:0] event_bits;
    logic [7:0] int_flags_view;
    logic       idle_expired;
    logic       wr_access;
    logic       rd_access;
    logic       addr_hit;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic is_write_to(input logic [7:0] off);
        is_write_to = wr_access && (paddr == off) && pstrb[0];
    endfunction : is_write_to

    function automatic logic [7:0] low_byte(input logic [31:0] w);
        low_byte = w[7:0];
    endfunction : low_byte

    // ---------------------------------------------------------------
    // apb decode: zero wait state, error on unmapped address
    // ---------------------------------------------------------------
    assign wr_access = ce && psel && penable && pwrite;
    assign rd_access = ce && psel && !penable && !pwrite;
    assign addr_hit  = (paddr == usb_err_pkg::error_flags_off)
                    || (paddr == usb_err_pkg::error_enables_off)
                    || (paddr == usb_err_pkg::int_flags_off)
                    || (paddr == usb_err_pkg::int_enables_off)
                    || (paddr == usb_err_pkg::control_off);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_hit;

    // ---------------------------------------------------------------
    // error events onto bit positions
    // ---------------------------------------------------------------
    always_comb begin
        event_bits = 8'h00;
        event_bits[usb_err_pkg::bit_stuff_bit]      =
            error_events.bit_stuff;                            // [RL6]
        event_bits[usb_err_pkg::turnaround_bit]     =
            error_events.turnaround;                           // [RL7]
        event_bits[usb_err_pkg::partial_byte_bit]   =
            error_events.partial_byte;                         // [RL8]
        event_bits[usb_err_pkg::data_crc_fail_bit]  =
            error_events.data_crc;                             // [RL9]
        event_bits[usb_err_pkg::token_crc_fail_bit] =
            error_events.token_crc;                            // [RL10]
        event_bits[usb_err_pkg::packet_id_fail_bit] =
            error_events.packet_id;                            // [RL11]
    end

    // ---------------------------------------------------------------
    // error flags: write zero clears, one keeps, event wins
    // ---------------------------------------------------------------
    always_comb begin
        usb_error_flags_d = usb_error_flags_q;
        if (is_write_to(usb_err_pkg::error_flags_off)) begin
            usb_error_flags_d = usb_error_flags_q
                                & low_byte(pwdata);            // [RL5] [RL19]
        end
        // events ignore enables and land at once [RL3] [RL4] [RL19]
        usb_error_flags_d = (usb_error_flags_d | event_bits)
                            & usb_err_pkg::error_impl_mask;    // [RL12]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            usb_error_flags_q <= usb_err_pkg::error_flags_rst;
        end else if (ce) begin
            usb_error_flags_q <= usb_error_flags_d;
        end
    end

    // ---------------------------------------------------------------
    // error enables
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            usb_error_enables_q <= usb_err_pkg::error_enable_rst;  // [RL13]
        end else if (is_write_to(usb_err_pkg::error_enables_off)) begin
            usb_error_enables_q <= low_byte(pwdata)
                                   & usb_err_pkg::error_impl_mask; // [RL12]
        end
    end

    // ---------------------------------------------------------------
    // summary: pure gating, no storage, so no clear path exists
    // ---------------------------------------------------------------
    assign usb_error_summary_flag =
        |(usb_error_flags_q & usb_error_enables_q);  // [RL1] [RL2] [RL17] [RL20]

    // ---------------------------------------------------------------
    // idle detect: bus_idle_flag sets after the quiet time
    // ---------------------------------------------------------------
    idle_timer #(
        .limit (idle_limit)
    ) u_idle (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .activity (bus_activity),
        .expired  (idle_expired)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_idle_flag_q <= 1'b0;
        end else if (ce) begin
            if (idle_expired) begin
                bus_idle_flag_q <= 1'b1;                       // [RL14]
            end else if (is_write_to(usb_err_pkg::int_flags_off)
                         && !pwdata[usb_err_pkg::bus_idle_bit]) begin
                bus_idle_flag_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt flags view and its enables
    // ---------------------------------------------------------------
    always_comb begin
        int_flags_view = 8'h00;
        int_flags_view[usb_err_pkg::summary_bit]  =
            usb_error_summary_flag;                            // [RL18]
        int_flags_view[usb_err_pkg::bus_idle_bit] = bus_idle_flag_q;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            int_enables_q <= usb_err_pkg::int_enable_rst;
        end else if (is_write_to(usb_err_pkg::int_enables_off)) begin
            int_enables_q <= low_byte(pwdata) & usb_err_pkg::int_impl_mask;
        end
    end

    assign usb_interrupt_request =
        |(int_flags_view & int_enables_q);                     // [RL18]

    // ---------------------------------------------------------------
    // control: module enable, pull-up, suspend
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            control_q <= usb_err_pkg::control_rst;
        end else if (is_write_to(usb_err_pkg::control_off)) begin
            control_q <= pwdata[2:0];
        end
    end

    assign module_enable = control_q[usb_err_pkg::module_enable_bit];
    // suspend never drops the pull-up; only a firmware write or reset turns it off
    assign pullup_enable =
        control_q[usb_err_pkg::pullup_enable_bit];             // [RL15]

    // ---------------------------------------------------------------
    // vbus sense: three stages, change taken when last two agree
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vbus_sync_q    <= 3'h0;
            vbus_present_q <= 1'b0;
        end else if (ce) begin
            vbus_sync_q <= {vbus_sync_q[1:0], vbus_sense};
            if (vbus_sync_q[1] == vbus_sync_q[2]) begin
                vbus_present_q <= vbus_sync_q[2];
            end
        end
    end

    // status only; firmware gates its enables on this [RL16]
    assign vbus_present = vbus_present_q;

    // ---------------------------------------------------------------
    // read data, registered in the setup cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_access) begin
            unique case (paddr)
                usb_err_pkg::error_flags_off:
                    prdata_q <= {24'h00_0000, usb_error_flags_q};
                usb_err_pkg::error_enables_off:
                    prdata_q <= {24'h00_0000, usb_error_enables_q};
                usb_err_pkg::int_flags_off:
                    prdata_q <= {24'h00_0000, int_flags_view};
                usb_err_pkg::int_enables_off:
                    prdata_q <= {24'h00_0000, int_enables_q};
                usb_err_pkg::control_off:
                    prdata_q <= {29'h000_0000, control_q};
                default:
                    prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;

endmodule : usb_error_flag_aggregator

// ==== bench/usb_error_flag_aggregator_properties.sv ====
// checker: port-level timing rules of the usb error block
`timescale 1ns/1ps
module usb_error_flag_aggregator_properties #(
    parameter int idle_limit = 20
) (
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire logic                          ce,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [7:0]                    paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [3:0]                    pstrb,
    input wire logic [31:0]                   prdata,
    input wire usb_err_pkg::error_events_type error_events,
    input wire logic                          usb_error_summary_flag,
    input wire logic                          pullup_enable
);
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite && pstrb[0] && ce;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ---------------------------------------------------------------
    // register writes at the access edge, no engine event alongside
    // ---------------------------------------------------------------
    sequence wr_s(logic [7:0] a, logic [7:0] d);
        apb_wr && paddr == a && pwdata[7:0] == d && !(|error_events);
    endsequence

    summary_fall_a: assert property (
        $fell(usb_error_summary_flag) |->
        $past(apb_wr && (paddr == 8'h00 || paddr == 8'h04)))
        else $error("summary fell without a register write");
    summary_rise_a: assert property (
        $rose(usb_error_summary_flag) |->
        $past(ce && (|error_events) || apb_wr && paddr == 8'h04))
        else $error("summary rose without event or enable write");
    mask_off_a: assert property (
        wr_s(8'h04, 8'h00) |=> !usb_error_summary_flag)
        else $error("summary high with every source masked");
    clear_zero_a: assert property (
        wr_s(8'h00, 8'h00) |=> !usb_error_summary_flag)
        else $error("summary high after all flags cleared");
    write_one_a: assert property (
        wr_s(8'h00, 8'hff) |=> $stable(usb_error_summary_flag))
        else $error("writing ones changed the summary");
    reserved_zero_a: assert property (
        psel && penable && !pwrite && (paddr == 8'h00 || paddr == 8'h04)
        |-> prdata[6:5] == 2'b00 && prdata[31:8] == 24'h0)
        else $error("unimplemented error bits read nonzero");
    summary_map_a: assert property (
        psel && !penable && !pwrite && ce && paddr == 8'h08 |=>
        prdata[1] == $past(usb_error_summary_flag))
        else $error("summary not at bit 1 of interrupt flags");
    pullup_hold_a: assert property (
        $fell(pullup_enable) |->
        $past(apb_wr && paddr == 8'h10 && !pwdata[1]))
        else $error("pull-up dropped without a control write");
endmodule : usb_error_flag_aggregator_properties

bind usb_error_flag_aggregator usb_error_flag_aggregator_properties #(
    .idle_limit(idle_limit)
) i_usb_error_flag_aggregator_properties (
    .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .error_events(error_events),
    .usb_error_summary_flag(usb_error_summary_flag),
    .pullup_enable(pullup_enable));

// ==== bench/sie_model.sv ====
// partner model: serial engine side feeding error events and traffic
`timescale 1ns/1ps
module sie_model (
    input  wire logic                    clk,
    output usb_err_pkg::error_events_type error_events,
    output logic                         bus_activity
);
    initial begin
        error_events = '0;
        bus_activity = 1'b1;
    end
    // one-cycle pulse only: holding the flag is the block's job
    task automatic pulse(input usb_err_pkg::error_events_type ev);
        error_events <= ev;
        @(posedge clk);
        error_events <= '0;
    endtask : pulse
    // host stops all traffic for n cycles, then resumes
    task automatic go_quiet(input int n);
        bus_activity <= 1'b0;
        repeat (n) @(posedge clk);
        bus_activity <= 1'b1;
    endtask : go_quiet
endmodule : sie_model

// ==== bench/test_usb_error_flag_aggregator.sv ====
// testbench: usb error block driven over apb with an engine model
`timescale 1ns/1ps
module test_usb_error_flag_aggregator;
    localparam int limit = 20;
    typedef struct packed {
        logic [31:0]                   en;
        usb_err_pkg::error_events_type ev;
        logic [31:0]                   flags;
        logic [31:0]                   en_rd;
        logic                          sum;
    } row_type;
    // one source per row; some enables miss their flag on purpose
    row_type rows [6] = '{
        '{32'h80, 6'h20, 32'h80, 32'h80, 1'b1},
        '{32'h10, 6'h10, 32'h10, 32'h10, 1'b1},
        '{32'h60, 6'h08, 32'h08, 32'h00, 1'b0},
        '{32'h04, 6'h04, 32'h04, 32'h04, 1'b1},
        '{32'h01, 6'h02, 32'h02, 32'h01, 1'b0},
        '{32'hff, 6'h01, 32'h01, 32'h9f, 1'b1}};
    logic        clk, rstn, ce, psel, penable, pwrite, vbus_sense;
    logic        pready, pslverr, err_seen, sum, irq, mod_en, pu_en, vb;
    logic        act;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rdata;
    usb_err_pkg::error_events_type ev;
    int          n_fail, checks_done;

    usb_error_flag_aggregator #(
        .idle_limit(limit)
    ) i_usb_error_flag_aggregator (
        .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .error_events(ev), .bus_activity(act), .vbus_sense(vbus_sense),
        .usb_error_summary_flag(sum), .usb_interrupt_request(irq),
        .module_enable(mod_en), .pullup_enable(pu_en), .vbus_present(vb));
    sie_model i_sie_model (.clk(clk), .error_events(ev), .bus_activity(act));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // entered just after an edge; waits one so strobes never double up
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdata    = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic report_and_stop();
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        {rstn, psel, penable, pwrite, vbus_sense} = 5'h0;
        ce          = 1'b1;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        pstrb       = 4'hf;
        n_fail      = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'h04, rows[i].en);
            wr(8'h00, 32'h0);
            i_sie_model.pulse(rows[i].ev);
            rd(8'h00);
            check(rdata, rows[i].flags);
            check({31'h0, sum}, {31'h0, rows[i].sum});
            rd(8'h04);
            check(rdata, rows[i].en_rd);
        end
        // clearing write and event land on the same edge
        fork
            wr(8'h00, 32'h0);
            begin
                repeat (2) @(posedge clk);
                i_sie_model.pulse(6'h01);
            end
        join
        rd(8'h00);
        check(rdata, 32'h01);
        wr(8'h00, 32'hff);
        rd(8'h00);
        check(rdata, 32'h01);
        rd(8'h08);
        check(rdata, 32'h02);
        wr(8'h08, 32'h0);
        rd(8'h08);
        check(rdata, 32'h02);
        wr(8'h0c, 32'h02);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        wr(8'h04, 32'h0);
        @(negedge clk);
        check({31'h0, sum}, 32'h0);
        wr(8'h04, 32'h01);
        wr(8'h00, 32'h0);
        @(negedge clk);
        check({30'h0, sum, irq}, 32'h0);
        wr(8'h0c, 32'h10);
        i_sie_model.go_quiet(limit - 5);
        rd(8'h08);
        check(rdata, 32'h0);
        i_sie_model.go_quiet(limit + 10);
        rd(8'h08);
        check({rdata[30:0], irq}, 32'h21);
        wr(8'h14, 32'hff);
        rd(8'h14);
        check({rdata[30:0], err_seen}, 32'h1);
        vbus_sense <= 1'b1;
        for (int k = 0; k < 10 && vb !== 1'b1; k++)
            @(negedge clk);
        check({31'h0, vb}, 32'h1);
        wr(8'h10, 32'h03);
        wr(8'h10, 32'h07);
        @(negedge clk);
        check({30'h0, mod_en, pu_en}, 32'h3);
        wr(8'h10, 32'h05);
        @(negedge clk);
        check({30'h0, mod_en, pu_en}, 32'h2);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check({30'h0, sum, pu_en}, 32'h0);
        check({30'h0, pready, pslverr}, 32'h2);
        for (int a = 0; a < 20; a += 4) begin
            rd(8'(a));
            check(rdata, 32'h0);
        end
        // clock enable low: an engine event must not land
        ce <= 1'b0;
        i_sie_model.pulse(6'h20);
        ce <= 1'b1;
        rd(8'h00);
        check(rdata, 32'h0);
        report_and_stop();
    end
endmodule : test_usb_error_flag_aggregator
